/* File: charger_cfg_pkg.sv */
// shared constants and types for the charger configuration register bank
package charger_cfg_pkg;

  // ----------------------------------------------------------------
  // link addressing and register map
  // ----------------------------------------------------------------
  localparam logic [6:0] TARGET_ADDR = 7'h6b;
  localparam int NUM_RW_REGS = 8;
  localparam logic [7:0] ADDR_INPUT_SOURCE = 8'h00;
  localparam logic [7:0] ADDR_POWER_ON = 8'h01;
  localparam logic [7:0] ADDR_CHARGE_CURRENT = 8'h02;
  localparam logic [7:0] ADDR_WATCHDOG_REG = 8'h05;
  localparam logic [7:0] ADDR_STATUS_FIRST = 8'h08;
  localparam logic [7:0] ADDR_STATUS_LAST = 8'h0a;
  localparam logic [7:0] RESET_VAL [0:7] = '{8'h30, 8'h1b, 8'h60, 8'h11,
                                            8'hb2, 8'h9a, 8'h03, 8'h4b};
  // bits outside a mask are fixed or self-clearing and keep their value
  localparam logic [7:0] WRITE_MASK [0:7] = '{8'hff, 8'h3e, 8'hfd, 8'hff,
                                             8'hff, 8'hfe, 8'h03, 8'hff};

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int HIGH_IMP_BIT = 7;
  localparam int REG_RESET_BIT = 7;
  localparam int WDT_KICK_BIT = 6;
  localparam int REDUCED_BIT = 0;

  // ----------------------------------------------------------------
  // field codes and scaling
  // ----------------------------------------------------------------
  localparam logic [2:0] IN_CUR_STD_LOW = 3'h0;
  localparam logic [2:0] IN_CUR_STD_HIGH = 3'h2;
  localparam logic [2:0] IN_CUR_DEDICATED = 3'h5;
  localparam logic [11:0] IN_CUR_MA [0:7] = '{12'h064, 12'h096, 12'h1f4,
    12'h384, 12'h4b0, 12'h5dc, 12'h7d0, 12'hbb8};
  localparam logic [12:0] VIN_OFFSET_MV = 13'hf28;
  localparam logic [12:0] VIN_STEP_MV = 13'h050;
  localparam logic [11:0] MINSYS_OFFSET_MV = 12'hbb8;
  localparam logic [11:0] MINSYS_STEP_MV = 12'h064;
  localparam logic [12:0] FAST_OFFSET_MA = 13'h200;
  localparam logic [12:0] FAST_STEP_MA = 13'h040;
  localparam logic [12:0] FAST_MAX_HIGH_MA = 13'h11c0;
  localparam logic [12:0] FAST_MAX_LOW_MA = 13'h09c0;
  localparam logic [17:0] REDUCED_PCT = 18'h00014;
  localparam logic [17:0] FULL_PCT = 18'h00064;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam longint CLK_FREQ_HZ = 64'h5f5e100;
  localparam longint WDT_BASE_S = 64'h28;
  localparam longint WDT_BASE_CYCLES_DFLT = WDT_BASE_S * CLK_FREQ_HZ;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_DISABLED = 3'b001,
    MODE_CHARGE = 3'b010,
    MODE_BOOST = 3'b100
  } charger_mode_t;

  typedef enum logic [6:0] {
    ST_IDLE = 7'b0000001,
    ST_DEV = 7'b0000010,
    ST_WR = 7'b0000100,
    ST_ACK = 7'b0001000,
    ST_RD = 7'b0010000,
    ST_RDACK = 7'b0100000,
    ST_RDNEXT = 7'b1000000
  } link_state_t;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] data;
  } link_req_t;

  typedef struct packed {
    logic high_impedance;
    logic [12:0] input_voltage_limit_mv;
    logic [11:0] input_current_limit_ma;
    charger_mode_t mode;
    logic [11:0] min_system_mv;
    logic [12:0] charge_current_ma;
  } charger_settings_t;

endpackage

/* File: charger_config_register_bank.sv */
// serial-link configuration register bank of a single-cell charger
// How it works
// - answers link address 0x6b; registers 0x00-0x07 are read and write
// - registers 0x08-0x0a show status inputs; writes leave them alone
// - input register bit 7 enables high-impedance input mode, reset 0
// - input voltage limit bits 6:3, 80mV steps over 3.88V, default 0110
// - input current limit bits 2:0 decode 100mA up to 3A
// - applied input current limit is lower of programmed and pin limit
// - default current code: 000/010 by boost pin, 101 on dedicated port
// - writing 1 to power-on bit 7 restores defaults, bit self-clears
// - writing 1 to power-on bit 6 restarts watchdog, bit self-clears
// - charger configuration bits 5:4: off, charge, boost; default 01
// - minimum system voltage bits 3:1, 0.1V steps over 3.0V, default 101
// - fast charge bits 7:2, 64mA steps over 512mA, capped per variant
// - charge register bit 0 applies 20 percent of the capped fast charge current
// - watchdog select 00 off, 01 40s, 10 80s, 11 160s; default 01
module charger_config_register_bank #(
  parameter bit HIGH_CURRENT_VARIANT = 1'b1,
  parameter longint WDT_BASE_CYCLES = charger_cfg_pkg::WDT_BASE_CYCLES_DFLT
) (
  // device clock, reset, enable
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // serial link
  input wire logic link_clk,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // source detection and limits
  input wire logic boost_mode_pin,
  input wire logic source_dedicated_port,
  input wire logic [11:0] external_current_limit_pin,
  input wire logic [2:0][7:0] status_in,
  // applied settings
  output charger_cfg_pkg::charger_settings_t settings,
  output logic watchdog_expired
);
  import charger_cfg_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
  logic start_det, stop_det, scl_rise, scl_fall, link_busy;
  link_state_t state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg, ptr_reg;
  logic rw_reg, first_byte_reg, oe_reg;
  link_req_t req_reg;
  logic req_tgl_reg, ack_s1, ack_s2;
  logic req_s1, req_s2, req_s3, ack_tgl_reg, take, wr_take, write_hit;
  logic boost_s1, boost_s2;
  logic reg_reset_cmd, wdt_kick, wdt_expire, load_defaults_reg;
  logic [7:0][7:0] regs_reg;
  logic [7:0] rd_data_reg, rd_mux;
  logic [2:0] in_cur_default;
  logic [35:0] wdt_cnt_reg, wdt_limit;
  logic [12:0] fast_prog, fast_capped;
  charger_settings_t settings_next;

  function automatic link_req_t make_req(input logic wr,
                                         input logic [7:0] addr,
                                         input logic [7:0] data);
    make_req = '{wr: wr, addr: addr, data: data};
  endfunction

  // ----------------------------------------------------------------
  // link side: pin synchronisers and bus events
  // ----------------------------------------------------------------
  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_d <= 1'b1;
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
    end else begin
      scl_s1 <= scl_in;
      scl_s2 <= scl_s1;
      scl_d <= scl_s2;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
      sda_d <= sda_s2;
      ack_s1 <= ack_tgl_reg;
      ack_s2 <= ack_s1;
    end
  end

  assign start_det = scl_s2 && scl_d && sda_d && !sda_s2;
  assign stop_det = scl_s2 && scl_d && !sda_d && sda_s2;
  assign scl_rise = scl_s2 && !scl_d;
  assign scl_fall = !scl_s2 && scl_d;
  // one request in flight; a write landing while busy is dropped
  assign link_busy = req_tgl_reg != ack_s2;
  assign sda_out = 1'b0;
  assign sda_oe = oe_reg;

  // ----------------------------------------------------------------
  // link side: target protocol engine
  // ----------------------------------------------------------------
  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      ptr_reg <= 8'h00;
      rw_reg <= 1'b0;
      first_byte_reg <= 1'b0;
      oe_reg <= 1'b0;
      req_reg <= '0;
      req_tgl_reg <= 1'b0;
    end else if (start_det) begin
      state_reg <= ST_DEV;
      bit_cnt_reg <= 4'h0;
      oe_reg <= 1'b0;
    end else if (stop_det) begin
      state_reg <= ST_IDLE;
      oe_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE: oe_reg <= 1'b0;
        ST_DEV, ST_WR: begin
          if (scl_rise) begin
            shift_reg <= {shift_reg[6:0], sda_s2};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (scl_fall && bit_cnt_reg == 4'h8) begin
            bit_cnt_reg <= 4'h0;
            if (state_reg == ST_DEV) begin
              if (shift_reg[7:1] == TARGET_ADDR) begin
                oe_reg <= 1'b1;
                rw_reg <= shift_reg[0];
                first_byte_reg <= !shift_reg[0];
                state_reg <= ST_ACK;
                if (shift_reg[0] && !link_busy) begin
                  req_reg <= make_req(1'b0, ptr_reg, 8'h00);
                  req_tgl_reg <= !req_tgl_reg;
                end
              end else begin
                state_reg <= ST_IDLE;
              end
            end else begin
              oe_reg <= 1'b1;
              state_reg <= ST_ACK;
              first_byte_reg <= 1'b0;
              if (first_byte_reg) begin
                ptr_reg <= shift_reg;
              end else begin
                ptr_reg <= ptr_reg + 8'h01;
                if (!link_busy) begin
                  req_reg <= make_req(1'b1, ptr_reg, shift_reg);
                  req_tgl_reg <= !req_tgl_reg;
                end
              end
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            bit_cnt_reg <= 4'h0;
            if (rw_reg) begin
              shift_reg <= rd_data_reg;
              oe_reg <= !rd_data_reg[7];
              ptr_reg <= ptr_reg + 8'h01;
              state_reg <= ST_RD;
            end else begin
              oe_reg <= 1'b0;
              state_reg <= ST_WR;
            end
          end
        end
        ST_RD: begin
          if (scl_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt_reg == 4'h8) begin
              oe_reg <= 1'b0;
              bit_cnt_reg <= 4'h0;
              state_reg <= ST_RDACK;
            end else begin
              shift_reg <= {shift_reg[6:0], 1'b0};
              oe_reg <= !shift_reg[6];
            end
          end
        end
        ST_RDACK: begin
          if (scl_rise) begin
            if (sda_s2) begin
              state_reg <= ST_IDLE;
            end else begin
              state_reg <= ST_RDNEXT;
              if (!link_busy) begin
                req_reg <= make_req(1'b0, ptr_reg, 8'h00);
                req_tgl_reg <= !req_tgl_reg;
              end
            end
          end
        end
        ST_RDNEXT: begin
          if (scl_fall) begin
            shift_reg <= rd_data_reg;
            oe_reg <= !rd_data_reg[7];
            ptr_reg <= ptr_reg + 8'h01;
            bit_cnt_reg <= 4'h0;
            state_reg <= ST_RD;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // device side: request crossing and pin synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      req_s3 <= 1'b0;
      boost_s1 <= 1'b0;
      boost_s2 <= 1'b0;
    end else if (clk_en) begin
      req_s1 <= req_tgl_reg;
      req_s2 <= req_s1;
      req_s3 <= req_s2;
      boost_s1 <= boost_mode_pin;
      boost_s2 <= boost_s1;
    end
  end

  // request word is held steady by the link until the ack returns
  assign take = clk_en && (req_s2 != req_s3);
  assign wr_take = take && req_reg.wr;
  assign write_hit = wr_take && (req_reg.addr < 8'h08);
  assign reg_reset_cmd = write_hit && req_reg.addr == ADDR_POWER_ON &&
                         req_reg.data[REG_RESET_BIT];
  assign wdt_kick = write_hit && req_reg.addr == ADDR_POWER_ON &&
                    req_reg.data[WDT_KICK_BIT];
  assign in_cur_default = source_dedicated_port ? IN_CUR_DEDICATED :
                          (boost_s2 ? IN_CUR_STD_HIGH : IN_CUR_STD_LOW);

  always_comb begin
    if (req_reg.addr < 8'h08) begin
      rd_mux = regs_reg[req_reg.addr[2:0]];
    end else if (req_reg.addr <= ADDR_STATUS_LAST) begin
      rd_mux = status_in[2'(req_reg.addr - ADDR_STATUS_FIRST)];
    end else begin
      rd_mux = 8'h00;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_tgl_reg <= 1'b0;
      rd_data_reg <= 8'h00;
    end else if (take) begin
      ack_tgl_reg <= !ack_tgl_reg;
      if (!req_reg.wr) begin
        rd_data_reg <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_RW_REGS; i++) begin
        regs_reg[i] <= RESET_VAL[i];
      end
      load_defaults_reg <= 1'b1;
    end else if (clk_en) begin
      // source-aware default needs live pins, so it loads after reset
      if (load_defaults_reg || reg_reset_cmd || wdt_expire) begin
        for (int i = 0; i < NUM_RW_REGS; i++) begin
          regs_reg[i] <= RESET_VAL[i];
        end
        regs_reg[0][2:0] <= in_cur_default;
        load_defaults_reg <= 1'b0;
      end else if (write_hit) begin
        // masked bits keep fixed values or self-clear
        regs_reg[req_reg.addr[2:0]] <=
          (req_reg.data & WRITE_MASK[req_reg.addr[2:0]]) |
          (regs_reg[req_reg.addr[2:0]] & ~WRITE_MASK[req_reg.addr[2:0]]);
      end
    end
  end

  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------
  always_comb begin
    unique case (regs_reg[5][5:4])
      2'b00: wdt_limit = 36'h0;
      2'b01: wdt_limit = 36'(WDT_BASE_CYCLES);
      2'b10: wdt_limit = 36'(WDT_BASE_CYCLES) << 1;
      2'b11: wdt_limit = 36'(WDT_BASE_CYCLES) << 2;
    endcase
  end

  assign wdt_expire = (wdt_limit != 36'h0) &&
                      (wdt_cnt_reg >= wdt_limit - 36'h1);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wdt_cnt_reg <= 36'h0;
      watchdog_expired <= 1'b0;
    end else if (clk_en) begin
      watchdog_expired <= wdt_expire;
      if (wdt_kick || wdt_expire || wdt_limit == 36'h0) begin
        wdt_cnt_reg <= 36'h0;
      end else begin
        wdt_cnt_reg <= wdt_cnt_reg + 36'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // applied settings
  // ----------------------------------------------------------------
  always_comb begin
    fast_prog = FAST_OFFSET_MA + 13'(regs_reg[2][7:2]) * FAST_STEP_MA;
    if (HIGH_CURRENT_VARIANT) begin
      fast_capped = (fast_prog > FAST_MAX_HIGH_MA) ? FAST_MAX_HIGH_MA :
                    fast_prog;
    end else begin
      fast_capped = (fast_prog > FAST_MAX_LOW_MA) ? FAST_MAX_LOW_MA :
                    fast_prog;
    end
    settings_next.high_impedance = regs_reg[0][HIGH_IMP_BIT];
    settings_next.input_voltage_limit_mv =
      VIN_OFFSET_MV + 13'(regs_reg[0][6:3]) * VIN_STEP_MV;
    settings_next.input_current_limit_ma =
      (IN_CUR_MA[regs_reg[0][2:0]] < external_current_limit_pin) ?
      IN_CUR_MA[regs_reg[0][2:0]] : external_current_limit_pin;
    unique case (regs_reg[1][5:4])
      2'b00: settings_next.mode = MODE_DISABLED;
      2'b01: settings_next.mode = MODE_CHARGE;
      2'b10, 2'b11: settings_next.mode = MODE_BOOST;
    endcase
    settings_next.min_system_mv =
      MINSYS_OFFSET_MV + 12'(regs_reg[1][3:1]) * MINSYS_STEP_MV;
    settings_next.charge_current_ma = regs_reg[2][REDUCED_BIT] ?
      13'((18'(fast_capped) * REDUCED_PCT) / FULL_PCT) : fast_capped;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      settings <= '{mode: MODE_DISABLED, default: '0};
    end else if (clk_en) begin
      settings <= settings_next;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_reg_reset;
    clk_en && reg_reset_cmd;
  endsequence

  sequence s_defaults_back;
    regs_reg[2] == RESET_VAL[2] && regs_reg[1] == RESET_VAL[1] &&
    regs_reg[5] == RESET_VAL[5];
  endsequence

  AST_ADDR_ACK: assert property (@(posedge link_clk) disable iff (!reset_n)
    (state_reg == ST_DEV && scl_fall && bit_cnt_reg == 4'h8 &&
     shift_reg[7:1] == TARGET_ADDR && !start_det && !stop_det)
    |=> (sda_oe && state_reg == ST_ACK))
    else $error("address match not acknowledged");
  AST_STATUS_RO: assert property (@(posedge clk) disable iff (!reset_n)
    (wr_take && req_reg.addr >= ADDR_STATUS_FIRST && !wdt_expire &&
     !load_defaults_reg) |=> $stable(regs_reg))
    else $error("write to read-only address changed registers");
  AST_HIGH_IMP: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en |=> settings.high_impedance == $past(regs_reg[0][7]))
    else $error("high impedance mode not following register");
  AST_VIN: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en |=> settings.input_voltage_limit_mv ==
      VIN_OFFSET_MV + 13'($past(regs_reg[0][6:3])) * VIN_STEP_MV)
    else $error("input voltage limit scaling wrong");
  AST_IN_CUR_MIN: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en |=> settings.input_current_limit_ma <=
      $past(external_current_limit_pin) &&
      settings.input_current_limit_ma <= IN_CUR_MA[$past(regs_reg[0][2:0])])
    else $error("applied input current above a limit");
  AST_DEFAULT_IN_CUR: assert property (@(posedge clk)
    disable iff (!reset_n)
    s_reg_reset |=> regs_reg[0][2:0] == $past(in_cur_default))
    else $error("source-aware current default not loaded");
  AST_REG_RESET: assert property (@(posedge clk) disable iff (!reset_n)
    s_reg_reset |=> s_defaults_back)
    else $error("register reset did not restore defaults");
  AST_WDT_KICK: assert property (@(posedge clk) disable iff (!reset_n)
    (clk_en && wdt_kick) |=> wdt_cnt_reg == 36'h0 && !regs_reg[1][6])
    else $error("watchdog kick did not restart timer");
  AST_MODE: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en |=> (settings.mode == MODE_BOOST) == $past(regs_reg[1][5]))
    else $error("charger mode decode wrong");
  AST_REDUCED: assert property (@(posedge clk) disable iff (!reset_n)
    (clk_en && regs_reg[2][0] && regs_reg[2][7:2] == 6'h3f)
    |=> settings.charge_current_ma ==
      (HIGH_CURRENT_VARIANT ? 13'h038c : 13'h01f3))
    else $error("reduced charge current not 20 percent");
  AST_RESERVED: assert property (@(posedge clk) disable iff (!reset_n)
    regs_reg[1][0] && !regs_reg[2][1] && regs_reg[1][7:6] == 2'b00)
    else $error("reserved or self-clearing bit has wrong value");
  AST_WDT_EXPIRE: assert property (@(posedge clk) disable iff (!reset_n)
    (clk_en && wdt_expire) |=> watchdog_expired ##0 s_defaults_back)
    else $error("watchdog expiry not handled");
endmodule

/* File: i2c_host_model.sv */
// serial link master standing in for the host processor
module i2c_host_model (
  // link lines
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // bit timing
  // ----
  // half bit, just above the 20 link clock minimum, keeps the run short
  localparam int H = 320;
  logic [7:0] rbuf [0:7];
  logic nack;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    nack = 1'b0;
  end
  task automatic bit_io(input logic b, output logic r);
    #(H/4) sda_low = !b;
    #(H*3/4) scl = 1'b1;
    #(H/2) r = sda;
    #(H/2) scl = 1'b0;
  endtask
  task automatic byte_io(input logic [7:0] d, input logic a,
                         output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(a, ack);
  endtask
  // start when stp is 0, stop when 1
  task automatic cond(input logic stp);
    #(H/4) sda_low = stp;
    #(H*3/4) scl = 1'b1;
    #H sda_low = !stp;
    #H scl = stp;
  endtask
  task automatic wr(input logic [6:0] dev, input logic [7:0] ra,
                    input logic [7:0] d);
    logic [7:0] q;
    logic a;
    cond(1'b0);
    byte_io({dev, 1'b0}, 1'b1, q, nack);
    byte_io(ra, 1'b1, q, a);
    byte_io(d, 1'b1, q, a);
    cond(1'b1);
  endtask
  task automatic rd(input logic [6:0] dev, input logic [7:0] ra,
                    input int n);
    logic [7:0] q;
    logic a;
    cond(1'b0);
    byte_io({dev, 1'b0}, 1'b1, q, nack);
    byte_io(ra, 1'b1, q, a);
    cond(1'b0);
    byte_io({dev, 1'b1}, 1'b1, q, a);
    // last byte refused so the target frees the line for stop
    for (int i = 0; i < n; i++) byte_io(8'hff, i == n - 1, rbuf[i], a);
    cond(1'b1);
  endtask
endmodule

/* File: tb_top.sv */
// self-checking bench for the charger configuration register bank
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import charger_cfg_pkg::*;
  // ----
  // set-up
  // ----
  // short watchdog base so one expiry fits in the run
  localparam longint WDT = 15000;
  localparam logic [11:0] IN_MA [0:7] = '{12'h064, 12'h096, 12'h1f4,
    12'h384, 12'h4b0, 12'h5dc, 12'h7d0, 12'hbb8};
  localparam charger_mode_t MODES [0:3] = '{MODE_DISABLED, MODE_CHARGE,
    MODE_BOOST, MODE_BOOST};
  logic clk, link_clk, reset_n, boost, dedicated, scl, sda_low, sda;
  logic sda_out, sda_oe, wd_pulse, en;
  logic [11:0] ext_lim;
  logic [2:0][7:0] status;
  charger_settings_t st;
  int err_total, compares, wd_count, n;
  assign sda = ~sda_low & ~(sda_oe & ~sda_out);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #3.3;
    forever #7.5 link_clk = ~link_clk;
  end
  charger_config_register_bank #(.HIGH_CURRENT_VARIANT(1'b1),
    .WDT_BASE_CYCLES(WDT)) i_dut (.clk(clk), .reset_n(reset_n),
    .clk_en(en), .link_clk(link_clk), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .boost_mode_pin(boost),
    .source_dedicated_port(dedicated), .external_current_limit_pin(ext_lim),
    .status_in(status), .settings(st), .watchdog_expired(wd_pulse));
  i2c_host_model i_host (.scl(scl), .sda_low(sda_low), .sda(sda));
  always @(posedge clk) if (wd_pulse === 1'b1) wd_count++;
  task automatic chk_val(input logic [12:0] got, input logic [12:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    chk_val({5'h00, got}, {5'h00, exp});
  endtask
  task automatic wr(input logic [7:0] ra, input logic [7:0] d);
    i_host.wr(TARGET_ADDR, ra, d);
    repeat (20) @(posedge clk);
  endtask
  task automatic rd1(input logic [7:0] ra, input logic [7:0] exp);
    i_host.rd(TARGET_ADDR, ra, 1);
    chk_reg(i_host.rbuf[0], exp);
  endtask
  task automatic tally_and_finish();
    if (err_total == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    // a little above the expected length of the whole test sequence
    #950us;
    err_total++;
    tally_and_finish();
  end
  // ----
  // tests
  // ----
  initial begin
    reset_n = 1'b0;
    en = 1'b1;
    boost = 1'b0;
    dedicated = 1'b0;
    ext_lim = 12'hfff;
    status = {8'h3c, 8'ha5, 8'h5a};
    repeat (12) @(posedge clk);
    #1 reset_n = 1'b1;
    repeat (50) @(posedge clk);
    i_host.rd(TARGET_ADDR, 8'h00, 8);
    chk_reg({7'h00, i_host.nack}, 8'h00);
    chk_reg({7'h00, sda_out}, 8'h00);
    for (int i = 0; i < 8; i++) begin
      chk_reg(i_host.rbuf[i], RESET_VAL[i]);
    end
    chk_val(st.input_voltage_limit_mv, 13'h1108);
    chk_val({1'b0, st.min_system_mv}, 13'h0dac);
    chk_val(st.charge_current_ma, 13'h0800);
    // watchdog off; expiry before the final test would show in wd_count
    wr(8'h05, 8'h8a);
    i_host.rd(TARGET_ADDR, 8'h08, 3);
    for (int i = 0; i < 3; i++) begin
      chk_reg(i_host.rbuf[i], status[i]);
    end
    wr(8'h08, 8'hff);
    rd1(8'h08, 8'h5a);
    wr(8'h02, 8'hff);
    rd1(8'h02, 8'hfd);
    chk_val(st.charge_current_ma, 13'h038c);
    wr(8'h02, 8'hfc);
    chk_val(st.charge_current_ma, 13'h11c0);
    for (int i = 0; i < 8; i++) begin
      wr(8'h00, {i[0], 4'(i), 3'(i)});
      chk_val({12'h000, st.high_impedance}, {12'h000, i[0]});
      chk_val(st.input_voltage_limit_mv, 13'hf28 + 13'h050 * 13'(i));
      chk_val({1'b0, st.input_current_limit_ma}, {1'b0, IN_MA[i]});
    end
    @(posedge clk);
    #1 ext_lim = 12'h12c;
    // enable low must freeze the applied settings
    en = 1'b0;
    repeat (4) @(posedge clk);
    chk_val({1'b0, st.input_current_limit_ma}, 13'h0bb8);
    #1 en = 1'b1;
    repeat (4) @(posedge clk);
    chk_val({1'b0, st.input_current_limit_ma}, 13'h012c);
    for (int i = 0; i < 4; i++) begin
      wr(8'h01, {2'b01, 2'(i), 3'(i), 1'b0});
      rd1(8'h01, {2'b00, 2'(i), 3'(i), 1'b1});
      chk_val({1'b0, st.min_system_mv}, 13'hbb8 + 13'h064 * 13'(i));
      chk_val({10'h000, st.mode}, {10'h000, MODES[i]});
    end
    i_host.wr(7'h6a, 8'h02, 8'h00);
    chk_reg({7'h00, i_host.nack}, 8'h01);
    rd1(8'h02, 8'hfc);
    chk_val(13'(wd_count), 13'h0000);
    @(posedge clk);
    #1 boost = 1'b1;
    wr(8'h01, 8'h80);
    i_host.rd(TARGET_ADDR, 8'h00, 3);
    chk_reg(i_host.rbuf[0], 8'h32);
    chk_reg(i_host.rbuf[1], 8'h1b);
    chk_reg(i_host.rbuf[2], 8'h60);
    @(posedge clk);
    #1 dedicated = 1'b1;
    wr(8'h01, 8'h5b);
    for (n = 0; n < WDT + 500 && wd_count == 0; n++) @(posedge clk);
    chk_val({12'h000, n > WDT - 1500}, 13'h0001);
    chk_val(13'(wd_count), 13'h0001);
    rd1(8'h00, 8'h35);
    tally_and_finish();
  end
endmodule
